// ### pkg/core_ctrl_pkg.sv
// Constants and types for the core control block: flag, address counter, stack.
// Assumes one clock domain and an APB master on the same clock.
package core_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Core widths and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned PC_W        = 14;
  localparam int unsigned SP_W        = 10;
  localparam int unsigned SP_LOW_W    = 6;
  localparam int unsigned STACK_DEPTH = 16;
  localparam int unsigned FRAME_W     = 16;

  localparam logic [3:0]          SP_FIXED_HI = 4'b1111;
  localparam logic [SP_LOW_W-1:0] SP_LOW_TOP  = 6'h3F;
  localparam logic [SP_LOW_W-1:0] SP_STEP     = 6'h04;
  localparam logic [SP_LOW_W-1:0] SP_LOW_LAST = 6'h03;
  localparam logic [PC_W-1:0]     PC_RESET    = 14'h0000;
  localparam logic [PC_W-1:0]     PC_ONE      = 14'h0001;
  localparam logic                FLAG_RESET  = 1'b1;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CMD         = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STATUS      = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_INT_STATUS  = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK    = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_INT_CTRL    = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_PORT_LATCH  = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_DPORT_DIR   = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_RPORT_DIR   = 12'h01C;
  localparam logic [ADDR_W-1:0] ADDR_PORT_MODE   = 12'h020;
  localparam logic [ADDR_W-1:0] ADDR_TIMER_MODE  = 12'h024;
  localparam logic [ADDR_W-1:0] ADDR_PRESCALE    = 12'h028;
  localparam logic [ADDR_W-1:0] ADDR_TIMER_COUNT = 12'h02C;

  // ----------------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------------
  localparam int unsigned CMD_OP_LSB     = 0;
  localparam int unsigned CMD_TARGET_LSB = 4;
  localparam int unsigned CMD_RESULT_BIT = 18;
  localparam int unsigned CMD_CARRY_BIT  = 19;

  // ----------------------------------------------------------------------
  // Event bits (int status and mask share this layout)
  // ----------------------------------------------------------------------
  localparam int unsigned EV_W         = 7;
  localparam int unsigned EV_BRANCH    = 0;
  localparam int unsigned EV_CALL      = 1;
  localparam int unsigned EV_INT       = 2;
  localparam int unsigned EV_RETURN    = 3;
  localparam int unsigned EV_SP_REINIT = 4;
  localparam int unsigned EV_OVERFLOW  = 5;
  localparam int unsigned EV_UNDERFLOW = 6;
  localparam logic [EV_W-1:0] EV_RESET = 7'h00;

  // Interrupt control: enable bit 0, request bit 1, mask bit 2
  localparam int unsigned     INTC_W     = 3;
  localparam logic [INTC_W-1:0] INTC_RESET = 3'b100;

  // ----------------------------------------------------------------------
  // Peripheral register reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0]  PORT_MODE_A_RESET  = 2'h0;
  localparam logic [3:0]  PORT_MODE_B_RESET  = 4'h0;
  localparam logic [2:0]  PORT_MODE_C_RESET  = 3'h0;
  localparam logic [3:0]  EDGE_SEL_RESET     = 4'h0;
  localparam logic [3:0]  TIMER_MODE_RESET   = 4'h0;
  localparam logic [3:0]  SERIAL_A_RESET     = 4'h0;
  localparam logic        SERIAL_B_RESET     = 1'b0;
  localparam logic [11:0] SYS_PRESCALE_RESET = 12'h000;
  localparam logic [7:0]  WATCH_PRESCALE_RESET = 8'h00;
  localparam logic [7:0]  TIMER_COUNT_RESET  = 8'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_STEP, OP_ALU, OP_BRANCH, OP_LONG_BRANCH, OP_CALL,
    OP_INT, OP_RTN, OP_RET_INT, OP_SP_REINIT
  } op_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic            flag;
    logic            carry;
  } stack_frame_t;

endpackage : core_ctrl_pkg

// ### logic/core_ctrl.sv
// Core control state: branch condition flag, address counter, stack pointer,
// sixteen-level stack and reset values of port, timer and serial registers.
// Assumes an APB master on CLK; instructions are issued as command writes.
// Reset is synchronous; every output comes straight from a flip-flop.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps

module core_ctrl
  import core_ctrl_pkg::*;
#(
  parameter int unsigned DPORT_W = 12,
  parameter int unsigned RPORT_W = 32,
  parameter int unsigned LATCH_W = 32
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output logic [31:0]            PRDATA,
  // Interrupt
  output logic                   IRQ,
  // Core state view
  output logic [PC_W-1:0]        INSTR_ADDR,
  output logic [SP_W-1:0]        STACK_PTR,
  output logic                   BRANCH_FLAG,
  output logic                   GLOBAL_INT_ENABLE,
  output logic                   INT_MASK_BIT
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                                  pready;
    logic                                  pslverr;
    logic [31:0]                           prdata;
    logic                                  irq;
    logic [PC_W-1:0]                       instr_address_counter;
    logic [SP_LOW_W-1:0]                   sp_low;
    logic                                  branch_condition_flag;
    logic                                  carry;
    stack_frame_t [STACK_DEPTH-1:0]        stack;
    logic [EV_W-1:0]                       int_status;
    logic [EV_W-1:0]                       int_mask;
    logic [INTC_W-1:0]                     int_ctrl;
    logic [LATCH_W-1:0]                    port_output_latch;
    logic [DPORT_W-1:0]                    dport_dir_ctrl;
    logic [RPORT_W-1:0]                    rport_dir_ctrl;
    logic [1:0]                            port_mode_a;
    logic [3:0]                            port_mode_b;
    logic [2:0]                            port_mode_c;
    logic [3:0]                            edge_select_1;
    logic [3:0]                            edge_select_2;
    logic [3:0]                            timer_a_mode;
    logic [3:0]                            timer_b_mode_1;
    logic [3:0]                            serial_mode_a;
    logic                                  serial_mode_b;
    logic [11:0]                           system_prescaler;
    logic [7:0]                            watch_prescaler;
    logic [3:0][7:0]                       timer_count;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] zext_word(input logic [31:0] v);
    zext_word = v;
  endfunction : zext_word

  // Full 10-bit pointer from the stored low bits
  function automatic logic [SP_W-1:0] full_sp(input logic [SP_LOW_W-1:0] lo);
    full_sp = {SP_FIXED_HI, lo};
  endfunction : full_sp

  // Frame index of a pointer value
  function automatic logic [3:0] frame_idx(input logic [SP_LOW_W-1:0] lo);
    frame_idx = lo[SP_LOW_W-1:2];
  endfunction : frame_idx

  // Frame saved by a call or interrupt entry
  function automatic stack_frame_t make_frame(input logic [PC_W-1:0] ret_addr,
                                              input logic            flag_in,
                                              input logic            carry_in);
    make_frame.pc    = ret_addr;
    make_frame.flag  = flag_in;
    make_frame.carry = carry_in;
  endfunction : make_frame

  // Pointer low bits after a push and after a pop
  function automatic logic [SP_LOW_W-1:0] sp_after_push(input logic [SP_LOW_W-1:0] lo);
    sp_after_push = lo - SP_STEP;
  endfunction : sp_after_push

  function automatic logic [SP_LOW_W-1:0] sp_after_pop(input logic [SP_LOW_W-1:0] lo);
    sp_after_pop = lo + SP_STEP;
  endfunction : sp_after_pop

  // Push from the deepest level, pop from level zero
  function automatic logic push_overflows(input logic [SP_LOW_W-1:0] lo);
    push_overflows = (lo == SP_LOW_LAST);
  endfunction : push_overflows

  function automatic logic pop_underflows(input logic [SP_LOW_W-1:0] lo);
    pop_underflows = (lo == SP_LOW_TOP);
  endfunction : pop_underflows

  // Address of the following instruction
  function automatic logic [PC_W-1:0] next_instr(input logic [PC_W-1:0] addr);
    next_instr = addr + PC_ONE;
  endfunction : next_instr

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic                access;
  logic                done_wr;
  logic [EV_W-1:0]     ev;
  logic [EV_W-1:0]     clr;
  logic [PC_W-1:0]     target;
  logic [PC_W-1:0]     pc_inc;
  logic [SP_LOW_W-1:0] sp_push;
  logic [SP_LOW_W-1:0] sp_pop;
  stack_frame_t        popped;
  op_t                 op;

  always_comb begin
    state_next = state_reg;
    access     = PSEL & PENABLE;
    done_wr    = access & state_reg.pready & PWRITE;
    ev         = '0;
    clr        = '0;
    target     = PWDATA[CMD_TARGET_LSB +: PC_W];
    pc_inc     = next_instr(state_reg.instr_address_counter);
    sp_push    = sp_after_push(state_reg.sp_low);
    sp_pop     = sp_after_pop(state_reg.sp_low);
    popped     = state_reg.stack[frame_idx(sp_pop)];
    op         = op_t'(PWDATA[CMD_OP_LSB +: 4]);

    // Answer one cycle into the access phase
    state_next.pready = access & ~state_reg.pready;

    // --------------------------------------------------------------------
    // Read data and error, prepared for the answering cycle
    // --------------------------------------------------------------------
    if (access && !state_reg.pready) begin
      state_next.pslverr = 1'b0;
      state_next.prdata  = '0;
      if (PADDR == ADDR_CMD) begin
        state_next.prdata = '0;
      end else if (PADDR == ADDR_STATUS) begin
        state_next.prdata = zext_word({4'h0, state_reg.carry, state_reg.branch_condition_flag,
                                       full_sp(state_reg.sp_low),
                                       2'b00, state_reg.instr_address_counter});
      end else if (PADDR == ADDR_INT_STATUS) begin
        state_next.prdata[EV_W-1:0] = state_reg.int_status;
      end else if (PADDR == ADDR_INT_MASK) begin
        state_next.prdata[EV_W-1:0] = state_reg.int_mask;
      end else if (PADDR == ADDR_INT_CTRL) begin
        state_next.prdata[INTC_W-1:0] = state_reg.int_ctrl;
      end else if (PADDR == ADDR_PORT_LATCH) begin
        state_next.prdata[LATCH_W-1:0] = state_reg.port_output_latch;
      end else if (PADDR == ADDR_DPORT_DIR) begin
        state_next.prdata[DPORT_W-1:0] = state_reg.dport_dir_ctrl;
      end else if (PADDR == ADDR_RPORT_DIR) begin
        state_next.prdata[RPORT_W-1:0] = state_reg.rport_dir_ctrl;
      end else if (PADDR == ADDR_PORT_MODE) begin
        // Bit 10 is not kept here and reads zero; port mode C bit 2 reads at bit 11
        state_next.prdata[19:0] = {state_reg.edge_select_2, state_reg.edge_select_1,
                                   state_reg.port_mode_c[2], 1'b0,
                                   state_reg.port_mode_c[1:0],
                                   state_reg.port_mode_b, 2'b00, state_reg.port_mode_a};
      end else if (PADDR == ADDR_TIMER_MODE) begin
        state_next.prdata[12:0] = {state_reg.serial_mode_b, state_reg.serial_mode_a,
                                   state_reg.timer_b_mode_1, state_reg.timer_a_mode};
      end else if (PADDR == ADDR_PRESCALE) begin
        state_next.prdata[19:0] = {state_reg.watch_prescaler, state_reg.system_prescaler};
      end else if (PADDR == ADDR_TIMER_COUNT) begin
        state_next.prdata = state_reg.timer_count;
      end else begin
        state_next.pslverr = 1'b1;
      end
    end

    // --------------------------------------------------------------------
    // Writes and command execution, at the completing edge
    // --------------------------------------------------------------------
    if (done_wr) begin
      if (PADDR == ADDR_CMD) begin
        case (op)
          OP_STEP: begin
            state_next.instr_address_counter = pc_inc;
          end
          OP_ALU: begin
            state_next.branch_condition_flag = PWDATA[CMD_RESULT_BIT];
            state_next.carry                 = PWDATA[CMD_CARRY_BIT];
            state_next.instr_address_counter = pc_inc;
          end
          OP_BRANCH, OP_LONG_BRANCH: begin
            if (state_reg.branch_condition_flag) begin
              state_next.instr_address_counter = target;
              ev[EV_BRANCH] = 1'b1;
            end else begin
              state_next.instr_address_counter = pc_inc;
            end
            state_next.branch_condition_flag = 1'b1;
          end
          OP_CALL: begin
            if (state_reg.branch_condition_flag) begin
              // Saved flag is the value before it is forced
              state_next.stack[frame_idx(state_reg.sp_low)] =
                make_frame(pc_inc, state_reg.branch_condition_flag,
                           state_reg.carry);
              state_next.sp_low = sp_push;
              state_next.instr_address_counter = target;
              ev[EV_CALL]     = 1'b1;
              ev[EV_OVERFLOW] = push_overflows(state_reg.sp_low);
            end else begin
              state_next.instr_address_counter = pc_inc;
            end
            state_next.branch_condition_flag = 1'b1;
          end
          OP_INT: begin
            // Flag is pushed and left as it is
            state_next.stack[frame_idx(state_reg.sp_low)] =
              make_frame(state_reg.instr_address_counter,
                         state_reg.branch_condition_flag, state_reg.carry);
            state_next.sp_low = sp_push;
            state_next.instr_address_counter = target;
            ev[EV_INT]      = 1'b1;
            ev[EV_OVERFLOW] = push_overflows(state_reg.sp_low);
          end
          OP_RTN: begin
            state_next.instr_address_counter = popped.pc;
            state_next.sp_low = sp_pop;
            ev[EV_RETURN]    = 1'b1;
            ev[EV_UNDERFLOW] = pop_underflows(state_reg.sp_low);
          end
          OP_RET_INT: begin
            state_next.instr_address_counter = popped.pc;
            state_next.branch_condition_flag = popped.flag;
            state_next.carry                 = popped.carry;
            state_next.sp_low = sp_pop;
            ev[EV_RETURN]    = 1'b1;
            ev[EV_UNDERFLOW] = pop_underflows(state_reg.sp_low);
          end
          OP_SP_REINIT: begin
            state_next.sp_low = SP_LOW_TOP;
            state_next.instr_address_counter = pc_inc;
            ev[EV_SP_REINIT] = 1'b1;
          end
          default: begin
            state_next.instr_address_counter = state_reg.instr_address_counter;
          end
        endcase
      end else if (PADDR == ADDR_INT_STATUS) begin
        clr = PWDATA[EV_W-1:0];
      end else if (PADDR == ADDR_INT_MASK) begin
        state_next.int_mask = PWDATA[EV_W-1:0];
      end else if (PADDR == ADDR_INT_CTRL) begin
        state_next.int_ctrl = PWDATA[INTC_W-1:0];
      end else if (PADDR == ADDR_PORT_LATCH) begin
        state_next.port_output_latch = PWDATA[LATCH_W-1:0];
      end else if (PADDR == ADDR_DPORT_DIR) begin
        state_next.dport_dir_ctrl = PWDATA[DPORT_W-1:0];
      end else if (PADDR == ADDR_RPORT_DIR) begin
        state_next.rport_dir_ctrl = PWDATA[RPORT_W-1:0];
      end else if (PADDR == ADDR_PORT_MODE) begin
        state_next.port_mode_a   = PWDATA[1:0];
        state_next.port_mode_b   = PWDATA[7:4];
        state_next.port_mode_c   = {PWDATA[11], PWDATA[9:8]};
        state_next.edge_select_1 = PWDATA[15:12];
        state_next.edge_select_2 = PWDATA[19:16];
      end else if (PADDR == ADDR_TIMER_MODE) begin
        state_next.timer_a_mode   = PWDATA[3:0];
        state_next.timer_b_mode_1 = PWDATA[7:4];
        state_next.serial_mode_a  = PWDATA[11:8];
        state_next.serial_mode_b  = PWDATA[12];
      end else if (PADDR == ADDR_PRESCALE) begin
        state_next.system_prescaler = PWDATA[11:0];
        state_next.watch_prescaler  = PWDATA[19:12];
      end else if (PADDR == ADDR_TIMER_COUNT) begin
        state_next.timer_count = PWDATA;
      end
    end

    // --------------------------------------------------------------------
    // Sticky events: a new event wins over a clear in the same cycle
    // --------------------------------------------------------------------
    state_next.int_status = (state_reg.int_status & ~clr) | ev;
    // IRQ shows at the same edge as the event's status bit
    state_next.irq        = |(state_next.int_status & state_next.int_mask);

    // --------------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------------
    if (RESET) begin
      // Clear all, then load reset values, zero ones included; int_mask, carry, stack and APB outputs stay cleared
      state_next                       = '0;
      state_next.instr_address_counter = PC_RESET;
      state_next.branch_condition_flag = FLAG_RESET;
      state_next.sp_low                = SP_LOW_TOP;
      state_next.int_status            = EV_RESET;
      state_next.int_ctrl              = INTC_RESET;
      state_next.port_output_latch     = '1;
      state_next.dport_dir_ctrl        = '0;
      state_next.rport_dir_ctrl        = '0;
      state_next.port_mode_a           = PORT_MODE_A_RESET;
      state_next.port_mode_b           = PORT_MODE_B_RESET;
      state_next.port_mode_c           = PORT_MODE_C_RESET;
      state_next.edge_select_1         = EDGE_SEL_RESET;
      state_next.edge_select_2         = EDGE_SEL_RESET;
      state_next.timer_a_mode          = TIMER_MODE_RESET;
      state_next.timer_b_mode_1        = TIMER_MODE_RESET;
      state_next.serial_mode_a         = SERIAL_A_RESET;
      state_next.serial_mode_b         = SERIAL_B_RESET;
      state_next.system_prescaler      = SYS_PRESCALE_RESET;
      state_next.watch_prescaler       = WATCH_PRESCALE_RESET;
      state_next.timer_count           = {4{TIMER_COUNT_RESET}};
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    state_reg <= state_next;
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------------
  assign PREADY            = state_reg.pready;
  assign PSLVERR           = state_reg.pslverr;
  assign PRDATA            = state_reg.prdata;
  assign IRQ               = state_reg.irq;
  assign INSTR_ADDR        = state_reg.instr_address_counter;
  assign STACK_PTR         = full_sp(state_reg.sp_low);
  assign BRANCH_FLAG       = state_reg.branch_condition_flag;
  assign GLOBAL_INT_ENABLE = state_reg.int_ctrl[0];
  assign INT_MASK_BIT      = state_reg.int_ctrl[2];

endmodule : core_ctrl

// ### verification/core_ctrl_props.sv
// Port checker for the core control block.
// Assumes a bind from the bench top; single clock, sync reset.
`timescale 1ns/1ps
module core_ctrl_props
  import core_ctrl_pkg::*;
(
  input wire logic              CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ,
  input wire logic              BRANCH_FLAG, GLOBAL_INT_ENABLE, INT_MASK_BIT,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA, PRDATA,
  input wire logic [PC_W-1:0]   INSTR_ADDR,
  input wire logic [SP_W-1:0]   STACK_PTR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  wire       cmd_done = PSEL && PENABLE && PREADY && PWRITE && PADDR == ADDR_CMD;
  wire [3:0] cmd_op   = PWDATA[3:0];
  chk_sp_upper: assert property (STACK_PTR[9:6] == SP_FIXED_HI)
    else $error("stack pointer upper bits not ones");
  chk_reset_core: assert property ($past(RESET) |->
    INSTR_ADDR == PC_RESET && BRANCH_FLAG && STACK_PTR == {SP_FIXED_HI, SP_LOW_TOP})
    else $error("core reset state wrong");
  chk_reset_ints: assert property ($past(RESET) |-> !GLOBAL_INT_ENABLE && INT_MASK_BIT)
    else $error("interrupt reset state wrong");
  chk_sp_step: assert property ($changed(STACK_PTR) && !$past(RESET) |->
    STACK_PTR[5:0] - $past(STACK_PTR[5:0]) inside {6'h04, 6'h3C} || &STACK_PTR)
    else $error("stack pointer moved by wrong amount");
  chk_state_cause: assert property (!$past(RESET) && ($changed(STACK_PTR) ||
    $changed(INSTR_ADDR) || $changed(BRANCH_FLAG)) |-> $past(cmd_done))
    else $error("core state changed without command");
  chk_flag_forced: assert property (cmd_done && cmd_op inside {OP_BRANCH, OP_LONG_BRANCH,
    OP_CALL} |=> BRANCH_FLAG)
    else $error("flag not forced after branch");
  chk_alu_flag: assert property (cmd_done && cmd_op == OP_ALU |=>
    BRANCH_FLAG == $past(PWDATA[CMD_RESULT_BIT]))
    else $error("flag did not take result");
  chk_int_push: assert property (cmd_done && cmd_op == OP_INT |=> BRANCH_FLAG ==
    $past(BRANCH_FLAG) && STACK_PTR[5:0] == $past(STACK_PTR[5:0]) - SP_STEP)
    else $error("interrupt entry wrong");
  chk_sp_reinit: assert property (cmd_done && cmd_op == OP_SP_REINIT |=> &STACK_PTR)
    else $error("stack pointer not reloaded");
  chk_ready_once: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("ready timing wrong");
  cover property (cmd_done && cmd_op == OP_CALL);
  cover property (cmd_done && cmd_op == OP_RET_INT);
  cover property ($rose(IRQ));
endmodule : core_ctrl_props

// ### verification/core_ctrl_tb.sv
// Self-checking bench for the core control block.
// Assumes the bench is the only APB master on CLK.
`timescale 1ns/1ps
module core_ctrl_tb
  import core_ctrl_pkg::*;
();
  logic              clk, reset, psel, penable, pwrite, pready, pslverr, irq, flag, gie, imask, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [PC_W-1:0]   pc;
  logic [SP_W-1:0]   sp;
  int                fail_count = 0;
  int                tests_run = 0;
  op_t ops [13] = '{OP_ALU, OP_STEP, OP_BRANCH, OP_LONG_BRANCH, OP_CALL, OP_ALU, OP_INT,
                    OP_ALU, OP_RET_INT, OP_RTN, OP_CALL, OP_CALL, OP_SP_REINIT};
  logic [PC_W-1:0] tg [13] = '{14'h0, 14'h0, 14'h0050, 14'h0050, 14'h0100, 14'h0, 14'h0200,
                               14'h0, 14'h0, 14'h0, 14'h0300, 14'h0300, 14'h0};
  logic [PC_W-1:0] epc [13] = '{14'h0001, 14'h0002, 14'h0003, 14'h0050, 14'h0100, 14'h0101,
                       14'h0200, 14'h0201, 14'h0101, 14'h0051, 14'h0052, 14'h0300, 14'h0301};
  logic [SP_W-1:0] esp [13] = '{10'h3FF, 10'h3FF, 10'h3FF, 10'h3FF, 10'h3FB, 10'h3FB, 10'h3F7,
                                10'h3F7, 10'h3FB, 10'h3FF, 10'h3FF, 10'h3FB, 10'h3FF};
  logic [12:0] rs  = 13'h0080;
  logic [12:0] efl = 13'h1C9C;
  logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h4, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'h0, 32'h0,
                           32'h0, 32'h0};
  core_ctrl u_core_ctrl (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr),
    .PRDATA(prdata), .IRQ(irq), .INSTR_ADDR(pc), .STACK_PTR(sp), .BRANCH_FLAG(flag),
    .GLOBAL_INT_ENABLE(gie), .INT_MASK_BIT(imask));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 8) begin
      @(posedge clk);
      n++;
    end
    chk(irq, v, "irq");
  endtask : wait_irq
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({pc, sp, flag, gie, imask}, {PC_RESET, 10'h3FF, 3'b101}, "core reset");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[26:0], {1'b1, 10'h3FF, 2'b00, PC_RESET}, "status");
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, ADDR_INT_STATUS + 12'(4 * i), 32'h0);
      chk(rd, rv[i], "reg reset");
    end
    apb(1'b0, 12'h100, 32'h0);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped");
    $display("test done: reset values");
    for (int i = 0; i < 13; i++) begin
      apb(1'b1, ADDR_CMD, {13'h0, rs[i], tg[i], ops[i]});
      chk({pc, sp, flag}, {epc[i], esp[i], efl[i]}, "core step");
    end
    $display("test done: commands");
    apb(1'b0, ADDR_INT_STATUS, 32'h0);
    chk({irq, rd}, {1'b0, 32'h1F}, "events");
    apb(1'b1, ADDR_INT_MASK, 32'h2);
    wait_irq(1'b1);
    apb(1'b1, ADDR_INT_STATUS, 32'h1F);
    wait_irq(1'b0);
    $display("test done: interrupt");
    apb(1'b1, ADDR_INT_CTRL, 32'h3);
    apb(1'b1, ADDR_PORT_LATCH, 32'h0);
    chk({gie, imask}, 2'b10, "int ctrl");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({pc, sp, flag, gie, imask}, {PC_RESET, 10'h3FF, 3'b101}, "rerun");
    apb(1'b0, ADDR_PORT_LATCH, 32'h0);
    chk(rd, 32'hFFFF_FFFF, "latch");
    apb(1'b1, ADDR_CMD, {28'h0, OP_RTN});
    chk(sp, 10'h3C3, "pop wraps");
    apb(1'b1, ADDR_CMD, {14'h0, 14'h0040, OP_CALL});
    chk({pc, sp}, {14'h0040, 10'h3FF}, "push wraps");
    apb(1'b0, ADDR_INT_STATUS, 32'h0);
    chk(rd, 32'h6A, "stack limit events");
    $display("test done: reset in run");
    summarize();
  end
endmodule : core_ctrl_tb
bind core_ctrl core_ctrl_props u_core_ctrl_props (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
  .BRANCH_FLAG(BRANCH_FLAG), .GLOBAL_INT_ENABLE(GLOBAL_INT_ENABLE), .INT_MASK_BIT(INT_MASK_BIT),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .INSTR_ADDR(INSTR_ADDR),
  .STACK_PTR(STACK_PTR));
